// ===== design/eap_pkg.sv
package eap_pkg;
    // ------------------------------------------------------------
    // configuration word fields
    // ------------------------------------------------------------
    localparam int CFG_ROT_LSB   = 0;   // default rotate amount
    localparam int CFG_ROT_W     = 5;
    localparam int CFG_FN_LSB    = 19;  // function code F0..F7
    localparam int CFG_INV_LSB   = 20;  // span flipped by false opcode
    localparam int CFG_INV_MSB   = 27;
    localparam int CFG_EXP_BIT   = 28;  // flag expansion replaces mask
    localparam int CFG_ARITH_BIT = 29;  // arithmetic instead of boolean
    localparam int CFG_ONE_BIT   = 30;  // force carry-in of one
    localparam int CFG_CIN_BIT   = 31;  // carry-in from status carry
    localparam int DATA_W        = 32;
    localparam int FLAGS_W       = 4;
    localparam int SEG_W         = 8;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [3:0]  FLAGS_RST  = 4'h0;

    // split sizes of the alu
    localparam logic [1:0] SS_32 = 2'h0;
    localparam logic [1:0] SS_16 = 2'h1;
    localparam logic [1:0] SS_8  = 2'h2;

    // operation variants
    localparam logic VAR_MPY = 1'b0;
    localparam logic VAR_ROT = 1'b1;

    // multiple arithmetic modifiers
    typedef enum logic [2:0] {
        FM_NONE   = 3'h0,
        FM_CARRY  = 3'h1,
        FM_SIGN   = 3'h2,
        FM_ZCARRY = 3'h3,
        FM_ZSIGN  = 3'h4,
        FM_RCARRY = 3'h5,
        FM_RSIGN  = 3'h6
    } eap_fmod_t;

    // ------------------------------------------------------------
    // condition codes, flags are {n, z, c, v}
    // ------------------------------------------------------------
    function automatic logic eap_cond_pass(input logic [3:0] code, input logic [3:0] f);
        logic n, z, c, v;
        n = f[3];
        z = f[2];
        c = f[1];
        v = f[0];
        case (code)
            4'h0:    eap_cond_pass = 1'b1;
            4'h1:    eap_cond_pass = 1'b0;
            4'h2:    eap_cond_pass = z;
            4'h3:    eap_cond_pass = ~z;
            4'h4:    eap_cond_pass = c;
            4'h5:    eap_cond_pass = ~c;
            4'h6:    eap_cond_pass = n;
            4'h7:    eap_cond_pass = ~n;
            4'h8:    eap_cond_pass = v;
            4'h9:    eap_cond_pass = ~v;
            4'ha:    eap_cond_pass = c & ~z;
            4'hb:    eap_cond_pass = ~c | z;
            4'hc:    eap_cond_pass = n ~^ v;
            4'hd:    eap_cond_pass = n ^ v;
            4'he:    eap_cond_pass = ~z & (n ~^ v);
            default: eap_cond_pass = z | (n ^ v);
        endcase
    endfunction
endpackage

// ===== design/eap_multiplier.sv
`timescale 1ns/1ns
// full, split, shifted and rounded multiply, purely combinational
module eap_multiplier (
    input  wire logic [31:0] mulA,
    input  wire logic [31:0] mulB,
    input  wire logic        signedMul,
    input  wire logic        splitMul,
    input  wire logic        roundMul,
    input  wire logic [1:0]  mulShift,
    output logic      [31:0] product
);
    logic [31:0] fullProd;
    logic [15:0] loProd;
    logic [15:0] hiProd;
    logic [31:0] rawProd;
    logic [31:0] shifted;
    logic [31:0] rounded;

    // ------------------------------------------------------------
    // products
    // ------------------------------------------------------------
    // 16x16 takes the low halfwords; sign extension keeps low 32 bits exact
    always_comb begin
        if (signedMul) begin
            fullProd = {{16{mulA[15]}}, mulA[15:0]} * {{16{mulB[15]}}, mulB[15:0]};
        end else begin
            fullProd = {16'h0000, mulA[15:0]} * {16'h0000, mulB[15:0]};
        end
    end

    // two 8x8 products
    // second source stays unsigned in a split multiply
    always_comb begin
        if (signedMul) begin
            loProd = {{8{mulA[7]}}, mulA[7:0]} * {8'h00, mulB[7:0]};
            hiProd = {{8{mulA[23]}}, mulA[23:16]} * {8'h00, mulB[23:16]};
        end else begin
            loProd = {8'h00, mulA[7:0]} * {8'h00, mulB[7:0]};
            hiProd = {8'h00, mulA[23:16]} * {8'h00, mulB[23:16]};
        end
    end

    // ------------------------------------------------------------
    // scaling and rounding
    // ------------------------------------------------------------
    // shift left, zero fill
    assign rawProd = splitMul ? {hiProd, loProd} : fullProd;
    assign shifted = rawProd << mulShift;
    assign rounded = shifted + {15'h0000, shifted[15], 16'h0000};

    assign product = roundMul ? {rounded[31:16], mulA[31:16]} : shifted;
endmodule

// ===== design/eap_datapath.sv
`timescale 1ns/1ns
// How it works
// - alu function comes from the config word; opcode routes operands and selects the false option
// - split multiply gives two independent 8x8 products of 16 bits
// - rounding adds bit 15 into bit 16 with carry ripple
// - rounded multiply puts third source high half into result low half
// - multiply output shifts left 0 to 3, zero filled, default zero
// - condition gates both writes together, any of 16 codes
// - rotate variant: third source is amount, rotate result writable, feeds B
// - rotate variant: fourth source drives C directly or through mask generator
// - carry modifier sets multiple flags from split segment carry outs
// - sign modifier sets multiple flags from split segment sign bits
// - zeroing modifiers clear the flags before inserting new bits
// - rotating modifiers rotate the flags while inserting new bits
// - false opcode inverts F1 to F7 of the function code, F0 is not inverted
// - inversion only when mask or flag expansion feeds C
// - multiply variant: C gets config mask or flag expansion
// - no immediates; constant amounts come from config rotate field
// - register rotate amounts come from the third source, not the config word
// - inversion covers config bits 27 to 20
// - false variant also inverts the carry in
// - masked C with expansion bit set uses the flag expansion
module eap_datapath (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 issue,
    input  wire logic                 variant,
    input  wire logic [31:0]          aluConfig,
    input  wire logic [31:0]          srcA,
    input  wire logic [31:0]          srcB,
    input  wire logic [31:0]          thirdSource,
    input  wire logic [31:0]          fourthSource,
    input  wire logic                 maskedC,
    input  wire logic                 falseOp,
    input  wire logic                 signedMpy,
    input  wire logic                 splitMpy,
    input  wire logic                 roundMpy,
    input  wire logic [1:0]           mulShift,
    input  wire eap_pkg::eap_fmod_t   fmod,
    input  wire logic [1:0]           splitSize,
    input  wire logic                 statusCarry,
    input  wire logic                 condEnable,
    input  wire logic [3:0]           condCode,
    input  wire logic [3:0]           condFlags,
    input  wire logic [4:0]           aluDestIn,
    input  wire logic [4:0]           mulRotDestIn,
    output logic [31:0]               aluResult,
    output logic                      aluWrite,
    output logic [4:0]                aluDest,
    output logic [31:0]               mulRotResult,
    output logic                      mulRotWrite,
    output logic [4:0]                mulRotDest,
    output logic [3:0]                multipleFlags,
    output logic                      aluCarryOut
);
    logic [31:0] aluResult_reg;
    logic        aluWrite_reg;
    logic [4:0]  aluDest_reg;
    logic [31:0] mulRotResult_reg;
    logic        mulRotWrite_reg;
    logic [4:0]  mulRotDest_reg;
    logic [3:0]  flags_reg;
    logic [3:0]  flags_next;
    logic        carry_reg;

    logic        effFalse;
    logic [31:0] ctrlWord;
    logic [7:0]  fnCode;
    logic [4:0]  rotAmt;
    logic [63:0] rotWide;
    logic [31:0] rotOut;
    logic [4:0]  maskAmt;
    logic [31:0] maskOut;
    logic [31:0] flagExp;
    logic [31:0] portC;
    logic [31:0] f0Vec;
    logic [31:0] fA1Vec;
    logic [31:0] opX;
    logic [31:0] opY;
    logic        carryIn;
    logic [31:0] sumOut;
    logic [3:0]  byteCarry;
    logic [3:0]  segStart;
    logic [3:0]  newBits;
    logic [3:0]  segMask;
    logic [31:0] mulProd;
    logic        writeOk;

    // ------------------------------------------------------------
    // function code and routing
    // ------------------------------------------------------------
    // inversion gate
    // a register driving C directly has no room for the false option
    assign effFalse = falseOp & ((variant == eap_pkg::VAR_MPY) | maskedC);

    always_comb begin
        ctrlWord = aluConfig;
        if (effFalse) begin
            ctrlWord[eap_pkg::CFG_INV_MSB:eap_pkg::CFG_INV_LSB] =
                ~aluConfig[eap_pkg::CFG_INV_MSB:eap_pkg::CFG_INV_LSB];
        end
    end
    assign fnCode = ctrlWord[eap_pkg::CFG_FN_LSB +: 8];

    assign rotAmt  = (variant == eap_pkg::VAR_ROT) ? thirdSource[4:0]
                   : aluConfig[eap_pkg::CFG_ROT_LSB +: eap_pkg::CFG_ROT_W];
    assign rotWide = {srcB, srcB} << rotAmt;
    assign rotOut  = rotWide[63:32];

    // mask generator: ones below the amount, zero amount gives no mask bits
    assign maskAmt = (variant == eap_pkg::VAR_ROT) ? fourthSource[4:0]
                   : aluConfig[eap_pkg::CFG_ROT_LSB +: eap_pkg::CFG_ROT_W];
    assign maskOut = ~(32'hffff_ffff << maskAmt);

    // flag expansion: each flag fills its split segment
    always_comb begin
        case (splitSize)
            eap_pkg::SS_16: flagExp = {{16{flags_reg[1]}}, {16{flags_reg[0]}}};
            eap_pkg::SS_8:  flagExp = {{8{flags_reg[3]}}, {8{flags_reg[2]}},
                                       {8{flags_reg[1]}}, {8{flags_reg[0]}}};
            default:        flagExp = {32{flags_reg[0]}};
        endcase
    end

    // C port selection
    always_comb begin
        if (variant == eap_pkg::VAR_ROT && !maskedC) begin
            portC = fourthSource;
        end else if (aluConfig[eap_pkg::CFG_EXP_BIT]) begin
            portC = flagExp;
        end else begin
            portC = maskOut;
        end
    end

    // ------------------------------------------------------------
    // three input alu
    // ------------------------------------------------------------
    // function as A&f1 + f2: f2 is F(0,B,C), f1 is F(1,B,C)^f2
    genvar gi;
    generate
        for (gi = 0; gi < eap_pkg::DATA_W; gi++) begin : g_fn
            assign f0Vec[gi]  = fnCode[{portC[gi], rotOut[gi], 1'b0}];
            assign fA1Vec[gi] = fnCode[{portC[gi], rotOut[gi], 1'b1}];
        end
    endgenerate

    always_comb begin
        if (aluConfig[eap_pkg::CFG_ARITH_BIT]) begin
            opX = srcA & (fA1Vec ^ f0Vec);
            opY = f0Vec;
        end else begin
            opX = (srcA & fA1Vec) | (~srcA & f0Vec);
            opY = 32'h0000_0000;
        end
    end

    always_comb begin
        if (aluConfig[eap_pkg::CFG_ONE_BIT]) begin
            carryIn = 1'b1 ^ effFalse;
        end else if (aluConfig[eap_pkg::CFG_CIN_BIT]) begin
            carryIn = statusCarry ^ effFalse;
        end else begin
            carryIn = effFalse;
        end
    end

    // byte adders; the chain breaks at each segment start
    generate
        for (gi = 0; gi < 4; gi++) begin : g_seg
            logic [8:0] byteSum;
            logic       byteCin;
            assign segStart[gi] = (gi == 0) || (splitSize == eap_pkg::SS_8)
                                || (splitSize == eap_pkg::SS_16 && gi == 2);
            if (gi == 0) begin : g_first
                assign byteCin = carryIn;
            end else begin : g_rest
                assign byteCin = segStart[gi] ? carryIn : byteCarry[gi-1];
            end
            assign byteSum = {1'b0, opX[gi*8 +: 8]} + {1'b0, opY[gi*8 +: 8]}
                           + {8'h00, byteCin};
            assign sumOut[gi*8 +: 8] = byteSum[7:0];
            assign byteCarry[gi]     = byteSum[8];
        end
    endgenerate

    // ------------------------------------------------------------
    // multiple flags update
    // ------------------------------------------------------------
    // carries or sign bits per segment
    always_comb begin
        logic carryMode;
        carryMode = (fmod == eap_pkg::FM_CARRY) || (fmod == eap_pkg::FM_ZCARRY)
                  || (fmod == eap_pkg::FM_RCARRY);
        case (splitSize)
            eap_pkg::SS_16: begin
                segMask = 4'h3;
                newBits = carryMode ? {2'h0, byteCarry[3], byteCarry[1]}
                                    : {2'h0, sumOut[31], sumOut[15]};
            end
            eap_pkg::SS_8: begin
                segMask = 4'hf;
                newBits = carryMode ? byteCarry
                                    : {sumOut[31], sumOut[23], sumOut[15], sumOut[7]};
            end
            default: begin
                segMask = 4'h1;
                newBits = carryMode ? {3'h0, byteCarry[3]} : {3'h0, sumOut[31]};
            end
        endcase
    end

    always_comb begin
        case (fmod)
            eap_pkg::FM_ZCARRY, eap_pkg::FM_ZSIGN: flags_next = newBits;
            eap_pkg::FM_RCARRY, eap_pkg::FM_RSIGN: begin
                case (splitSize)
                    eap_pkg::SS_16: flags_next = {flags_reg[1:0], newBits[1:0]};
                    eap_pkg::SS_8:  flags_next = newBits;
                    default:        flags_next = {flags_reg[2:0], newBits[0]};
                endcase
            end
            eap_pkg::FM_CARRY, eap_pkg::FM_SIGN: flags_next = (flags_reg & ~segMask) | newBits;
            default: flags_next = flags_reg;
        endcase
    end

    // ------------------------------------------------------------
    // multiplier
    // ------------------------------------------------------------
    eap_multiplier u_mul (
        .mulA      (thirdSource),
        .mulB      (fourthSource),
        .signedMul (signedMpy),
        .splitMul  (splitMpy),
        .roundMul  (roundMpy),
        .mulShift  (mulShift),
        .product   (mulProd)
    );

    // ------------------------------------------------------------
    // write back
    // ------------------------------------------------------------
    // one condition for both writes
    // destinations trusted as issued by the decoder
    assign writeOk = issue & (~condEnable | eap_pkg::eap_cond_pass(condCode, condFlags));

    // results and write strobes, one cycle after issue
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aluResult_reg    <= eap_pkg::RESULT_RST;
            mulRotResult_reg <= eap_pkg::RESULT_RST;
            aluWrite_reg     <= 1'b0;
            mulRotWrite_reg  <= 1'b0;
            aluDest_reg      <= 5'h00;
            mulRotDest_reg   <= 5'h00;
            carry_reg        <= 1'b0;
        end else begin
            aluWrite_reg    <= writeOk;
            mulRotWrite_reg <= writeOk;
            if (issue) begin
                aluResult_reg <= sumOut;
                carry_reg     <= byteCarry[3];
                aluDest_reg   <= aluDestIn;
                mulRotDest_reg <= mulRotDestIn;
                mulRotResult_reg <= (variant == eap_pkg::VAR_ROT) ? rotOut : mulProd;
            end
        end
    end

    // flags register; a blocked condition leaves the flags alone
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= eap_pkg::FLAGS_RST;
        end else if (writeOk) begin
            flags_reg <= flags_next;
        end
    end

    assign aluResult     = aluResult_reg;
    assign aluWrite      = aluWrite_reg;
    assign aluDest       = aluDest_reg;
    assign mulRotResult  = mulRotResult_reg;
    assign mulRotWrite   = mulRotWrite_reg;
    assign mulRotDest    = mulRotDest_reg;
    assign multipleFlags = flags_reg;
    assign aluCarryOut   = carry_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_write_pair: assert property (issue && !condEnable |=> aluWrite && mulRotWrite)
        else $error("unconditional issue missed a write");
    a_cond_block: assert property (
        issue && condEnable && !eap_pkg::eap_cond_pass(condCode, condFlags)
        |=> !aluWrite && !mulRotWrite)
        else $error("write despite failed condition");
    a_split_mul: assert property (
        issue && variant == eap_pkg::VAR_MPY && splitMpy && !roundMpy && !signedMpy
        && mulShift == 2'h0 |=> mulRotResult ==
        {16'($past(thirdSource[23:16]) * $past(fourthSource[23:16])),
         16'($past(thirdSource[7:0]) * $past(fourthSource[7:0]))})
        else $error("split multiply wrong");
    a_round_low: assert property (
        issue && variant == eap_pkg::VAR_MPY && roundMpy
        |=> mulRotResult[15:0] == $past(thirdSource[31:16]))
        else $error("rounded low half wrong");
    a_shift_fill: assert property (
        issue && variant == eap_pkg::VAR_MPY && !roundMpy && mulShift == 2'h3
        |=> mulRotResult[2:0] == 3'h0)
        else $error("shift fill not zero");
    a_rot_result: assert property (
        issue && variant == eap_pkg::VAR_ROT |=>
        ((mulRotResult >> $past(thirdSource[4:0]))
        | (mulRotResult << (6'd32 - {1'b0, $past(thirdSource[4:0])}))) == $past(srcB))
        else $error("rotate result wrong");
    a_false_gate: assert property (
        variant == eap_pkg::VAR_ROT && !maskedC |-> fnCode == aluConfig[eap_pkg::CFG_FN_LSB +: 8])
        else $error("inversion with direct C");
    a_flags_zero: assert property (
        writeOk && fmod == eap_pkg::FM_ZCARRY && splitSize == eap_pkg::SS_16
        |=> multipleFlags[3:2] == 2'h0)
        else $error("flags not zeroed");
    a_flags_rotate: assert property (
        writeOk && fmod == eap_pkg::FM_RSIGN && splitSize == eap_pkg::SS_16
        |=> multipleFlags[3:2] == $past(multipleFlags[1:0]))
        else $error("flags not rotated");
    a_flags_carry: assert property (
        writeOk && fmod == eap_pkg::FM_CARRY && splitSize == eap_pkg::SS_8
        |=> multipleFlags == $past(byteCarry))
        else $error("carry flags wrong");

    c_split_mul: cover property (issue && splitMpy && variant == eap_pkg::VAR_MPY);
    c_rot_false: cover property (issue && variant == eap_pkg::VAR_ROT && effFalse);
    c_cond_skip: cover property (issue && condEnable && !writeOk);
endmodule

// ===== test/eap_regfile_model.sv
`timescale 1ns/1ns
// ----
// register file of the issuing processor
// ----
module eap_regfile_model (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        aluWrite,
    input  wire logic [4:0]  aluDest,
    input  wire logic [31:0] aluResult,
    input  wire logic        mulRotWrite,
    input  wire logic [4:0]  mulRotDest,
    input  wire logic [31:0] mulRotResult,
    output int               pairErr
);
    logic [31:0] dataRegs [32];
    // data register targets
    // no global transfer is modelled, so every destination is a data register
    // paired write-back
    // a lone strobe would retire half an instruction
    // the error count survives a mid-run reset so the final tally still sees it
    always_ff @(posedge sys_clk) begin
        if (resetn) begin
            if (aluWrite !== mulRotWrite) pairErr <= pairErr + 1;
            if (aluWrite === 1'b1) dataRegs[aluDest] <= aluResult;
            if (mulRotWrite === 1'b1) dataRegs[mulRotDest] <= mulRotResult;
        end
    end
endmodule

// ===== test/eap_datapath_test.sv
`timescale 1ns/1ns
module eap_datapath_test;
    logic        sys_clk, resetn, issue, variant, maskedC, falseOp;
    logic        signedMpy, splitMpy, roundMpy, statusCarry, condEnable;
    logic [31:0] aluConfig, srcA, srcB, thirdSource, fourthSource, aluResult, mulRotResult;
    logic [1:0]  mulShift, splitSize;
    logic [3:0]  condCode, condFlags, multipleFlags;
    logic [4:0]  aluDestIn, mulRotDestIn, aluDest, mulRotDest;
    logic        aluWrite, mulRotWrite, aluCarryOut;
    int          fail_count, checks_done, pairErr;
    eap_pkg::eap_fmod_t fmod;
    localparam logic [15:0] PASS_SET = 16'ha659; // passing codes for flags n=1 z=0 c=1 v=0
    eap_datapath i_dut (.sys_clk(sys_clk), .resetn(resetn), .issue(issue), .variant(variant),
        .aluConfig(aluConfig), .srcA(srcA), .srcB(srcB), .thirdSource(thirdSource),
        .fourthSource(fourthSource), .maskedC(maskedC), .falseOp(falseOp), .signedMpy(signedMpy),
        .splitMpy(splitMpy), .roundMpy(roundMpy), .mulShift(mulShift), .fmod(fmod),
        .splitSize(splitSize), .statusCarry(statusCarry), .condEnable(condEnable),
        .condCode(condCode), .condFlags(condFlags), .aluDestIn(aluDestIn), .mulRotDestIn(mulRotDestIn),
        .aluResult(aluResult), .aluWrite(aluWrite), .aluDest(aluDest), .mulRotResult(mulRotResult),
        .mulRotWrite(mulRotWrite), .mulRotDest(mulRotDest), .multipleFlags(multipleFlags),
        .aluCarryOut(aluCarryOut));
    eap_regfile_model i_rf (.sys_clk(sys_clk), .resetn(resetn), .aluWrite(aluWrite), .aluDest(aluDest),
        .aluResult(aluResult), .mulRotWrite(mulRotWrite), .mulRotDest(mulRotDest),
        .mulRotResult(mulRotResult), .pairErr(pairErr));
    // ----
    // helpers
    // ----
    // free running core clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rotl(input logic [31:0] x, input logic [4:0] n);
        logic [63:0] t;
        t = {x, x} << n;
        return t[63:32];
    endfunction
    function automatic logic [31:0] mask(input logic [4:0] n);
        return ~(32'hffff_ffff << n);
    endfunction
    // single segment reference, good for split size 32 only
    function automatic logic [32:0] alu_ref(input logic [31:0] cfg, a, b, c, input logic f);
        logic [31:0] e, p, q, r;
        logic        cin;
        e = f ? cfg ^ 32'h0ff0_0000 : cfg;
        for (int i = 0; i < 32; i++) begin
            q[i] = e[19 + {c[i], b[i], 1'b0}];
            p[i] = e[19 + {c[i], b[i], 1'b1}] ^ q[i];
            r[i] = e[19 + {c[i], b[i], a[i]}];
        end
        cin = (cfg[30] | (cfg[31] & statusCarry)) ^ f;
        return cfg[29] ? {1'b0, a & p} + {1'b0, q} + cin : {1'b0, r} + cin;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one issue, returns just after the edge that answers it
    task automatic fire();
        issue = 1'b1;
        @(posedge sys_clk);
        #1 issue = 1'b0;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_route();
        variant = eap_pkg::VAR_ROT;
        srcB = 32'h8000_0001;
        thirdSource = 32'h0000_0004;
        fourthSource = 32'h1234_5678;
        aluConfig = 32'h0660_001f;
        issue = 1'b1;
        @(posedge sys_clk);
        #1 aluConfig = 32'h0780_0000;
        check(mulRotResult, 32'h0000_0018);
        check(aluResult, 32'h0000_0018);
        check({27'h0, mulRotDest}, 32'h0000_0004);
        fire();
        check(aluResult, 32'h1234_5678);
        check(i_rf.dataRegs[4], 32'h0000_0018);
        check({27'h0, aluDest}, 32'h0000_0003);
        maskedC = 1'b1;
        fourthSource = 32'h0000_0008;
        fire();
        check(aluResult, 32'h0000_00ff);
        $display("test route done");
    endtask
    task automatic t_false();
        logic [32:0] r;
        variant = eap_pkg::VAR_MPY;
        aluConfig = 32'h2330_0003;
        srcA = 32'h0000_0100;
        srcB = 32'h0000_0011;
        for (int f = 0; f < 2; f++) begin
            falseOp = f[0];
            fire();
            r = alu_ref(aluConfig, srcA, rotl(srcB, 5'h03), mask(5'h03), falseOp);
            check(aluResult, r[31:0]);
            check({31'h0, aluCarryOut}, {31'h0, r[32]});
        end
        variant = eap_pkg::VAR_ROT;
        thirdSource = 32'h0000_0000;
        fourthSource = 32'h0000_0085;
        for (int m = 0; m < 2; m++) begin
            maskedC = m[0];
            fire();
            r = alu_ref(aluConfig, srcA, srcB, m[0] ? mask(5'h05) : fourthSource, m[0]);
            check(aluResult, r[31:0]);
        end
        $display("test false done");
    endtask
    task automatic t_mpy();
        variant = eap_pkg::VAR_MPY;
        aluConfig = 32'h0000_0000;
        thirdSource = 32'hffff_1234;
        fourthSource = 32'hffff_0010;
        for (int s = 0; s < 4; s++) begin
            mulShift = s[1:0];
            fire();
            check(mulRotResult, 32'h0001_2340 << s);
        end
        mulShift = 2'h0;
        splitMpy = 1'b1;
        thirdSource = 32'h0005_0007;
        fourthSource = 32'h0003_0009;
        fire();
        check(mulRotResult, 32'h000f_003f);
        signedMpy = 1'b1;
        thirdSource = 32'h00ff_0007;
        fourthSource = 32'h0002_0009;
        fire();
        check(mulRotResult, 32'hfffe_003f);
        {splitMpy, signedMpy, roundMpy, mulShift} = 5'h05;
        thirdSource = 32'habcd_4000;
        fourthSource = 32'h0000_0001;
        fire();
        check(mulRotResult, 32'h0001_abcd);
        {roundMpy, mulShift} = 3'h0;
        $display("test multiply done");
    endtask
    task automatic t_cond();
        {condEnable, condFlags} = 5'h1a;
        for (int i = 0; i < 16; i++) begin
            condCode = i[3:0];
            fire();
            check({30'h0, aluWrite, mulRotWrite}, {30'h0, {2{PASS_SET[i]}}});
        end
        condEnable = 1'b0;
        @(posedge sys_clk);
        #1 check({31'h0, aluWrite}, 32'h0000_0000);
        $display("test condition done");
    endtask
    task automatic step(input eap_pkg::eap_fmod_t m, input logic [1:0] ss, input logic [31:0] a, b,
                        input logic [3:0] want);
        fmod = m;
        splitSize = ss;
        srcA = a;
        srcB = b;
        fire();
        check({28'h0, multipleFlags}, {28'h0, want});
    endtask
    task automatic t_flags();
        {variant, maskedC, falseOp} = 3'h4;
        aluConfig = 32'h2330_0000;
        step(eap_pkg::FM_CARRY, 2'h2, 32'h00ff_8001, 32'h0001_8001, 4'h6);
        step(eap_pkg::FM_RCARRY, 2'h1, 32'h0001_8000, 32'h0000_8000, 4'h9);
        step(eap_pkg::FM_ZCARRY, 2'h1, 32'h0001_8000, 32'h0000_8000, 4'h1);
        step(eap_pkg::FM_SIGN, 2'h1, 32'h8000_0000, 32'h0000_0000, 4'h2);
        step(eap_pkg::FM_ZSIGN, 2'h2, 32'h8000_8000, 32'h0000_0000, 4'ha);
        step(eap_pkg::FM_RSIGN, 2'h1, 32'h0000_8000, 32'h0000_0000, 4'h9);
        {condEnable, condCode} = 5'h11;
        step(eap_pkg::FM_ZCARRY, 2'h1, 32'h0001_8000, 32'h0000_8000, 4'h9);
        // flags 1001 expanded per byte on C, plus carry in per segment
        variant = eap_pkg::VAR_MPY;
        splitSize = 2'h2;
        statusCarry = 1'b1;
        aluConfig = 32'h9780_0000;
        fire();
        check(aluResult, 32'h0001_0100);
        statusCarry = 1'b0;
        fire();
        check(aluResult, 32'hff00_00ff);
        resetn = 1'b0;
        #5 check({28'h0, multipleFlags}, 32'h0000_0000);
        @(posedge sys_clk);
        #1 resetn = 1'b1;
        @(posedge sys_clk);
        #1 check({27'h0, aluWrite, multipleFlags}, 32'h0000_0000);
        $display("test flags done");
    endtask
    // ----
    // main sequence and hang guard
    // ----
    initial begin
        {resetn, issue, variant, maskedC, falseOp, signedMpy, splitMpy, roundMpy} = 8'h00;
        {statusCarry, condEnable, mulShift, splitSize, condCode, condFlags} = 14'h0000;
        {aluConfig, srcA, srcB, thirdSource, fourthSource} = 160'h0;
        aluDestIn = 5'h03;
        mulRotDestIn = 5'h04;
        fmod = eap_pkg::FM_NONE;
        fail_count = 0;
        checks_done = 0;
        repeat (20) @(posedge sys_clk);
        #1 resetn = 1'b1;
        check({27'h0, aluWrite, multipleFlags}, 32'h0000_0000);
        t_route();
        t_false();
        t_mpy();
        t_cond();
        t_flags();
        check(32'(pairErr), 32'h0000_0000);
        final_report();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end
endmodule
